// [logic/cpmc_top.v]
// Pump enable and ratio control with four LED current source drivers.
// Assumes an APB master on clk and asynchronous analog dropout flags on pins.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "cpmc_defs.vh"

module cpmc_top #(
   parameter DEB_LONG = `CPMC_DEB_LONG_TICKS,
   parameter DEB_SHORT = `CPMC_DEB_SHORT_TICKS
)
(
   input wire clk,
   input wire nrst,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [3:0] src_dropout,
   input wire [3:0] src_hw_gate,
   input wire [3:0] pattern_cycle_end,
   output reg pump_on,
   output reg pump_ratio,
   output reg pump_clk_tick,
   output reg [3:0] src_on,
   output reg [7:0] led_source_1,
   output reg [7:0] led_source_2,
   output reg [7:0] led_source_3,
   output reg [7:0] led_source_4
);

   // --------------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------------
   // Software registers, pin synchronisers and control state. Every output of this
   // module is itself a flip-flop, so the analog side never sees decode glitches.
   // All of it freezes while clk_en is low.
   reg [7:0] reg_ctrl_r;
   reg [7:0] pump_ctrl_r;
   reg [7:0] src_mode_r;
   reg [31:0] src_cur_r;
   reg [3:0] drop_s1_r;
   reg [3:0] drop_s2_r;
   reg [3:0] gate_s1_r;
   reg [3:0] gate_s2_r;
   reg [3:0] pend_s1_r;
   reg [3:0] pend_s2_r;
   reg [3:0] pend_d_r;
   reg [3:0] cut_r;
   reg [7:0] div_r;
   reg [14:0] deb_r;
   reg man_latched_r;
   reg ratio_auto_r;

   wire pump_manual_enable = reg_ctrl_r[`CPMC_BIT_MAN_EN];
   wire pump_auto_enable = pump_ctrl_r[`CPMC_BIT_AUTO_EN];
   wire pump_debounce_select = pump_ctrl_r[`CPMC_BIT_DEB_SEL];
   wire ratio_manual_select = pump_ctrl_r[`CPMC_BIT_RATIO_MAN];
   wire pump_clock_select = pump_ctrl_r[`CPMC_BIT_CLK_SEL];

   // Decodes a two-bit source mode into an enabled flag.
   function mode_enabled;
      input [1:0] m;
      begin
         mode_enabled = (m != 2'h0);
      end
   endfunction

   // Flags a source running from the pattern generator.
   function is_pattern;
      input [1:0] m;
      begin
         is_pattern = (m == 2'h3);
      end
   endfunction

   // Source enable, before and after hardware gating.
   wire [3:0] src_en;
   wire [3:0] src_live;
   wire [3:0] src_pat;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_en
         assign src_en[g] = mode_enabled(src_mode_r[2*g+1:2*g]) & ~cut_r[g];
         // Pattern-mode sources are the only ones cut at a cycle end.
         assign src_pat[g] = is_pattern(src_mode_r[2*g+1:2*g]);
         assign src_live[g] = src_en[g] &
            ((src_mode_r[2*g+1:2*g] == 2'h1) | gate_s2_r[g]);
      end
   endgenerate

   wire any_en = |src_en;
   wire any_drop = |(drop_s2_r & src_en);
   // Ratio in use: the software bit in manual switching, the sticky automatic
   // choice otherwise. Reads of the ratio field show this, not the written bit.
   wire ratio_now = ratio_manual_select ? pump_ctrl_r[`CPMC_BIT_RATIO] : ratio_auto_r;

   // --------------------------------------------------------------------------
   // APB slave, zero wait states
   // --------------------------------------------------------------------------
   // The answer is registered: pready, pslverr and prdata are loaded at the setup
   // edge and stand through the single access cycle. A master that leaves penable
   // low for longer only stretches the setup; the slave never inserts wait states.
   // Upper data bits of the 8-bit registers read as zero.
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_reg = (paddr == `CPMC_OFS_REG_CTRL);
   wire hit_pump = (paddr == `CPMC_OFS_PUMP_CTRL);
   wire hit_mode = (paddr == `CPMC_OFS_SRC_MODE);
   wire hit_cur = (paddr == `CPMC_OFS_SRC_CUR);
   wire hit_stat = (paddr == `CPMC_OFS_STATUS);
   wire hit_any = hit_reg | hit_pump | hit_mode | hit_cur | hit_stat;
   reg [31:0] rd_nxt;

   // Selects read data; the ratio field shows the ratio in use.
   always @*
   begin
      rd_nxt = 32'h00000000;
      if (hit_reg)
         rd_nxt = {24'h000000, reg_ctrl_r};
      else if (hit_pump)
         rd_nxt = {24'h000000, pump_ctrl_r[7:3], ratio_now, pump_ctrl_r[1:0]};
      else if (hit_mode)
         rd_nxt = {24'h000000, src_mode_r};
      else if (hit_cur)
         rd_nxt = src_cur_r;
      else if (hit_stat)
         // Status shows source enables before gating, dropout, manual latch, pump state and ratio.
         rd_nxt = {24'h000000, src_en, any_drop, man_latched_r, pump_on, ratio_now};
   end

   // Register writes and bus answer.
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         reg_ctrl_r <= `CPMC_RST_REG_CTRL;
         pump_ctrl_r <= `CPMC_RST_PUMP_CTRL;
         src_mode_r <= `CPMC_RST_SRC_MODE;
         src_cur_r <= `CPMC_RST_SRC_CUR;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h00000000;
         // A write lands only at the access edge, while pready already stands high.
         // Unmapped addresses match no register, so such writes are dropped.
         if (wr & pready & hit_reg)
            reg_ctrl_r <= pwdata[7:0];
         if (wr & pready & hit_pump)
            pump_ctrl_r <= pwdata[7:0];
         if (wr & pready & hit_mode)
            src_mode_r <= pwdata[7:0];
         if (wr & pready & hit_cur)
            src_cur_r <= pwdata;
      end
   end

   // --------------------------------------------------------------------------
   // Pin synchronisers and pattern-end cut-off
   // --------------------------------------------------------------------------
   // Dropout, gate and pattern-end pins come from the analog side with no relation
   // to clk. Each passes two flip-flops; only the second stage feeds logic, so a
   // metastable first stage never reaches the debounce or enable decisions.
   // The pattern-end edge detector resets to the idle low level of its pin.
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         drop_s1_r <= 4'h0;
         drop_s2_r <= 4'h0;
         gate_s1_r <= 4'h0;
         gate_s2_r <= 4'h0;
         pend_s1_r <= 4'h0;
         pend_s2_r <= 4'h0;
         pend_d_r <= 4'h0;
         cut_r <= 4'h0;
      end
      else if (clk_en)
      begin
         drop_s1_r <= src_dropout;
         drop_s2_r <= drop_s1_r;
         gate_s1_r <= src_hw_gate;
         gate_s2_r <= gate_s1_r;
         pend_s1_r <= pattern_cycle_end;
         pend_s2_r <= pend_s1_r;
         pend_d_r <= pend_s2_r;
         // pattern end switches off
         // Only a rising end marker cuts, so a held marker costs one cycle of light.
         cut_r <= pend_s2_r & ~pend_d_r & src_pat;
      end
   end

   // --------------------------------------------------------------------------
   // Pump clock divider
   // --------------------------------------------------------------------------
   // Divider end values, cut to the counter width on purpose.
   localparam [31:0] DIV_1M_W = `CPMC_PCLK_1M_DIV - 1;
   localparam [31:0] DIV_500K_W = `CPMC_PCLK_500K_DIV - 1;
   wire [7:0] div_max = pump_clock_select ? DIV_500K_W[7:0] : DIV_1M_W[7:0];
   wire tick = (div_r >= div_max);

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_r <= 8'h00;
         pump_clk_tick <= 1'b0;
      end
      else if (clk_en)
      begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         pump_clk_tick <= tick;
      end
   end

   // --------------------------------------------------------------------------
   // Debounce, ratio and enable control
   // --------------------------------------------------------------------------
   // The debounce counts pump clock ticks, so at the slower pump clock the
   // debounce time doubles; the other length cannot restore the same time, as the
   // two lengths differ far more than twofold. Any gap in dropout restarts the count, so short dips under the
   // threshold never raise the ratio. The automatic ratio is sticky: only
   // switching every source off clears it.
   // debounce length
   wire [14:0] deb_lim = pump_debounce_select ? DEB_SHORT[14:0] : DEB_LONG[14:0];
   wire deb_done = (deb_r >= deb_lim - 15'h0001);
   // Manual path latches on until its bit is cleared; automatic path needs an enabled
   // source and drops out as soon as every source is off. Either path runs the
   // pump.
   wire pump_nxt = (pump_manual_enable & (man_latched_r | (any_en & any_drop))) |
      (pump_auto_enable & any_en & (pump_on | any_drop));

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         deb_r <= 15'h0000;
         ratio_auto_r <= 1'b0;
         man_latched_r <= 1'b0;
         pump_on <= 1'b0;
         pump_ratio <= 1'b0;
         src_on <= 4'h0;
      end
      else if (clk_en)
      begin
         if (!any_en)
         begin
            deb_r <= 15'h0000;
            ratio_auto_r <= 1'b0;
         end
         else if (!any_drop)
            deb_r <= 15'h0000;
         else if (tick & !deb_done)
            deb_r <= deb_r + 15'h0001;
         else if (tick & deb_done)
            ratio_auto_r <= 1'b1;
         if (!pump_manual_enable)
            man_latched_r <= 1'b0;
         else if (any_en & any_drop)
            man_latched_r <= 1'b1;
         pump_on <= pump_nxt;
         pump_ratio <= ratio_now;
         src_on <= src_live;
      end
   end

   // A source that is off or gated drives a zero code, so the analog current
   // source never sees a stale setting when it is next switched on.
   // Bit 7 of each code carries the largest weight.
   // per-source current codes
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         led_source_1 <= 8'h00;
         led_source_2 <= 8'h00;
         led_source_3 <= 8'h00;
         led_source_4 <= 8'h00;
      end
      else if (clk_en)
      begin
         led_source_1 <= src_live[0] ? src_cur_r[7:0] : 8'h00;
         led_source_2 <= src_live[1] ? src_cur_r[15:8] : 8'h00;
         led_source_3 <= src_live[2] ? src_cur_r[23:16] : 8'h00;
         led_source_4 <= src_live[3] ? src_cur_r[31:24] : 8'h00;
      end
   end

endmodule // cpmc_top

// [pkg/cpmc_defs.vh]
// Constants for the pump mode control block: register offsets, field positions,
// reset values and timing counts. Assumes a 100 MHz system clock.
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
// Register indices; each register is one aligned word, so byte address is four times index.
`define CPMC_IDX_REG_CTRL 12'h000
`define CPMC_IDX_PUMP_CTRL 12'h023
`define CPMC_OFS_REG_CTRL 12'h000
`define CPMC_OFS_PUMP_CTRL 12'h08C
`define CPMC_OFS_SRC_MODE 12'h040
`define CPMC_OFS_SRC_CUR 12'h044
`define CPMC_OFS_STATUS 12'h048
`define CPMC_BIT_MAN_EN 2
`define CPMC_BIT_AUTO_EN 6
`define CPMC_BIT_DEB_SEL 5
`define CPMC_BIT_RATIO_MAN 4
`define CPMC_BIT_RATIO 2
`define CPMC_BIT_CLK_SEL 0
`define CPMC_RST_REG_CTRL 8'h00
`define CPMC_RST_PUMP_CTRL 8'h40
`define CPMC_RST_SRC_MODE 8'h03
`define CPMC_RST_SRC_CUR 32'h00000040

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CPMC_CLK_MHZ 100
`define CPMC_PCLK_1M_DIV (`CPMC_CLK_MHZ / 1)
`define CPMC_PCLK_500K_DIV (`CPMC_CLK_MHZ * 2)
`define CPMC_DEB_LONG_US 32000
`define CPMC_DEB_SHORT_US 240
// Debounce counts in 1 MHz pump-clock ticks, one per microsecond.
`define CPMC_DEB_LONG_TICKS `CPMC_DEB_LONG_US
`define CPMC_DEB_SHORT_TICKS `CPMC_DEB_SHORT_US

`endif

// [verif/cpmc_chk_checker.sv]
// Assertions on the ports of the pump mode control block.
// Assumes it is bound to cpmc_top with clk_en held high.
`timescale 1ns/1ps
module cpmc_chk
(
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire pump_ratio,
   input wire pump_clk_tick,
   input wire [3:0] src_on,
   input wire [3:0] src_dropout,
   input wire [7:0] led_source_1
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // --------------------------------------------------------------
   // Bus phases
   // --------------------------------------------------------------
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   apb_answer_a: assert property (setup_s |=> access_s ##0 pready)
      else $error("no answer after setup");
   ready_access_a: assert property (pready |-> access_s)
      else $error("ready outside access");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   tick_pulse_a: assert property (pump_clk_tick |=> !pump_clk_tick [*8])
      else $error("pump tick too fast");
   led_off_a: assert property (!src_on[0] [*2] |-> led_source_1 == 8'h00)
      else $error("dead source drives code");
   ratio_fall_a: assert property ($fell(pump_ratio) |-> src_on == 4'h0
      || $past(src_on) == 4'h0 || $past(src_on, 2) == 4'h0 || $past(pwrite))
      else $error("ratio lowered while sources live");
   ratio_rise_a: assert property ($rose(pump_ratio)
      |-> $past(pwrite) || $past(src_dropout, 3) != 4'h0)
      else $error("ratio raised without dropout");
endmodule // cpmc_chk

// [verif/cpmc_src_model.sv]
// Model of the four LED current sources on the pump output rail.
// Assumes the bench asks for low headroom per source on low_req.
`timescale 1ns/1ps
module cpmc_src_model
(
   input wire [3:0] src_on,
   input wire [3:0] low_req,
   output wire [3:0] src_dropout
);
   // per source flag
   // A source that is off draws no current, so it never shows dropout.
   assign src_dropout = src_on & low_req;
endmodule // cpmc_src_model

// [verif/tb_charge_pump_mode_control.sv]
// Self-checking bench for the pump mode control block.
// Assumes cpmc_top with short debounce counts and an APB master here.
`timescale 1ns/1ps
module tb_charge_pump_mode_control;
   logic clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic pump_on, pump_ratio, pump_clk_tick, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] src_dropout, src_hw_gate, pattern_cycle_end, src_on, low_req;
   logic [7:0] led_source_1, led_source_2, led_source_3, led_source_4;
   int n_errors = 0;
   int num_checks = 0;
   int n;
   cpmc_top #(.DEB_LONG(8), .DEB_SHORT(4)) u_cpmc_top (.clk(clk), .nrst(nrst),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_dropout(src_dropout), .src_hw_gate(src_hw_gate),
      .pattern_cycle_end(pattern_cycle_end), .pump_on(pump_on), .pump_ratio(pump_ratio),
      .pump_clk_tick(pump_clk_tick), .src_on(src_on), .led_source_1(led_source_1),
      .led_source_2(led_source_2), .led_source_3(led_source_3),
      .led_source_4(led_source_4));
   cpmc_src_model u_cpmc_src_model (.src_on(src_on), .low_req(low_req),
      .src_dropout(src_dropout));
   // Clock at 100 MHz.
   always #5 clk = ~clk;
   // --------------------------------------------------------------
   // Bus and compare helpers
   // --------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge clk); penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata; rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task t_regs;
      apb(0, 12'h08C, 0); chk("pump_control", 32'h40, rdat);
      apb(0, 12'h000, 0); chk("regulator_control", 0, rdat);
      apb(0, 12'h0FC, 0); chk("unmapped err", 1, rerr);
      chk("unmapped data", 0, rdat);
      $display("regs done");
   endtask
   task t_auto;
      apb(1, 12'h040, 32'h03);
      src_hw_gate <= 4'h1; apb(1, 12'h08C, 32'h60); low_req <= 4'h1;
      for (n = 0; n < 5000 && pump_ratio !== 1'b1; n++) @(posedge clk);
      chk("ratio up", 1, pump_ratio);
      chk("debounce span", 1, n >= 300);
      chk("short debounce", 1, n <= 500);
      chk("auto pump", 1, pump_on);
      apb(0, 12'h08C, 0); chk("ratio read", 32'h64, rdat);
      low_req <= 4'h0; repeat (1000) @(posedge clk);
      chk("no step down", 1, pump_ratio);
      pattern_cycle_end <= 4'h1; repeat (3) @(posedge clk); pattern_cycle_end <= 4'h0;
      repeat (20) @(posedge clk); chk("pattern end", 0, pump_ratio);
      apb(1, 12'h040, 0); repeat (20) @(posedge clk);
      chk("auto off", 0, pump_on);
      chk("ratio reset", 0, pump_ratio);
      apb(1, 12'h08C, 32'h40); apb(1, 12'h040, 32'h01); low_req <= 4'h1;
      for (n = 0; n < 5000 && pump_ratio !== 1'b1; n++) @(posedge clk);
      chk("long debounce", 1, n >= 690 && n <= 900);
      low_req <= 4'h0; apb(1, 12'h040, 0); repeat (20) @(posedge clk);
      $display("auto done");
   endtask
   task t_manual;
      apb(1, 12'h000, 32'h04); apb(1, 12'h08C, 32'h14); apb(1, 12'h040, 32'h01);
      low_req <= 4'h1;
      for (n = 0; n < 5000 && pump_on !== 1'b1; n++) @(posedge clk);
      chk("manual start", 1, pump_on);
      chk("manual ratio", 1, pump_ratio);
      low_req <= 4'h0; apb(1, 12'h040, 0); repeat (20) @(posedge clk);
      chk("manual hold", 1, pump_on);
      apb(1, 12'h08C, 32'h10); repeat (5) @(posedge clk);
      chk("ratio 1:1", 0, pump_ratio);
      apb(0, 12'h08C, 0); chk("ratio read", 32'h10, rdat);
      $display("manual done");
   endtask
   task t_current;
      apb(1, 12'h044, 32'h000080A5); apb(1, 12'h040, 32'h05); repeat (5) @(posedge clk);
      chk("led1", 8'hA5, led_source_1);
      chk("led2", 8'h80, led_source_2);
      chk("led3", 8'h00, led_source_3);
      chk("led4", 8'h00, led_source_4);
      chk("src on", 4'h3, src_on);
      apb(1, 12'h08C, 32'h01);
      for (n = 0; n < 500 && pump_clk_tick !== 1'b1; n++) @(posedge clk);
      n = 0;
      do @(posedge clk); while (pump_clk_tick !== 1'b1 && ++n < 500);
      chk("tick span", 199, n);
      $display("current done");
   endtask
   // Reset, run the scenarios, then give the verdict.
   initial
   begin
      clk = 0; nrst = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; src_hw_gate = 0; pattern_cycle_end = 0; low_req = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs; t_auto; t_manual; t_current;
      conclude;
   end
   // Cut a hang short.
   initial
   begin
      #500000;
      n_errors++;
      conclude;
   end
endmodule // tb_charge_pump_mode_control
bind cpmc_top cpmc_chk u_cpmc_chk (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .pump_ratio(pump_ratio), .pump_clk_tick(pump_clk_tick), .src_on(src_on),
   .src_dropout(src_dropout), .led_source_1(led_source_1));
